// file: design/tcgev_defines.svh
`ifndef TCGEV_DEFINES_SVH
`define TCGEV_DEFINES_SVH
// ****************************************
// Register byte offsets on the bus
// ****************************************
`define TCGEV_ADDR_W 8
`define TCGEV_OFF_CTRL 8'h00
`define TCGEV_OFF_DUR 8'h04
`define TCGEV_OFF_READER_MATCH_TIME 8'h08
`define TCGEV_OFF_GENERATOR_MATCH_TIME 8'h0c
`define TCGEV_OFF_ARM 8'h10
`define TCGEV_OFF_UB 8'h14
`define TCGEV_OFF_STAT 8'h18
// ****************************************
// Field positions and reset values
// ****************************************
`define TCGEV_CTRL_W 12
`define TCGEV_CTRL_RST 12'h000
`define TCGEV_CTRL_RCTL 0
`define TCGEV_CTRL_CONV 1
`define TCGEV_CTRL_IN1 2
`define TCGEV_CTRL_OUT1 6
`define TCGEV_DUR_RST 8'h01
`define TCGEV_ARM_RDR_ONE 0
`define TCGEV_ARM_RDR_CONT 1
`define TCGEV_ARM_GEN_ONE 2
`define TCGEV_ARM_GEN_CONT 3
`define TCGEV_UB_SRC 8
`define TCGEV_UB_MARK 8'h80
`define TCGEV_RESP_OKAY 2'h0
`define TCGEV_RESP_SLVERR 2'h2
// ****************************************
// Contact pin positions
// ****************************************
`define TCGEV_NPIN 8
`define TCGEV_PIN_CHAR 0
`define TCGEV_PIN_RESYNC 1
`define TCGEV_PIN_IN1 2
`define TCGEV_PIN_VITC 6
`define TCGEV_PIN_BYP 7
// ****************************************
// Timing
// ****************************************
`define TCGEV_CLK_KHZ 50000
`define TCGEV_DEB_MS 5
`define TCGEV_DEB_CYC (`TCGEV_DEB_MS * `TCGEV_CLK_KHZ)
`endif

// file: design/tcgev_pkg.sv
`default_nettype none
package tcgev_pkg;
	// ****************************************
	// Shared types
	// ****************************************
	typedef struct packed {
		logic [7:0] hh;
		logic [7:0] mm;
		logic [7:0] ss;
		logic [7:0] ff;
	} tcgev_tc_t;
	typedef enum logic [2:0] {
		EVT_OFF = 3'h1,
		EVT_ONE = 3'h2,
		EVT_CONT = 3'h4
	} tcgev_evt_t;
	typedef enum logic [1:0] {
		GPI_LTC = 2'h0,
		GPI_VITC = 2'h1,
		GPI_HOLD = 2'h2,
		GPI_SET = 2'h3
	} tcgev_gpi_fn_t;
	typedef enum logic [2:0] {
		GPO_RDR = 3'h0,
		GPO_GEN = 3'h1,
		GPO_SEC = 3'h2,
		GPO_MIN = 3'h3,
		GPO_REF = 3'h4
	} tcgev_gpo_fn_t;
endpackage
`default_nettype wire

// file: design/tcgev_gpio.sv
// How it works
// - Remote-user-bit mode: six inputs pick user bits; vitc, bypass stay.
// - Inputs 1..6 give user byte 81,82,84,88,90,A0 hex.
// - Parallel source is default; an edge on any of the six parallel pins reselects it.
// - Normal mode: two dedicated (inserter, resync) and two assignable inputs work again.
// - Falling edge on inserter input toggles inserter, same as panel key.
// - Vitc enable: falling edge turns generator on, rising turns off.
// - Bypass relay energized while bypass input is low.
// - Resync press and release loads reader time, unless in convert mode.
// - Assignable input: ltc, vitc, hold or set; fall on, rise off.
// - Generator set input low reloads last entered time every frame.
// - Outside remote-user-bit mode, assignable outputs are pulled low while their condition holds.
// - Reader event output pulses on armed reader time match.
// - Generator event output pulses on armed generator time match.
// - Second tick output pulses at each generator second start.
// - Minute tick output pulses at each generator minute start.
// - Reference failure output held while genlock reference is missing.
// - One frame-counted duration, reset 01, serves both outputs.
// - Event register: off, single or continuous; commands toggle arming.
// - Single arming fires on first match then disarms.
// - Continuous arming fires on every match.
`timescale 1ns/1ps
`include "tcgev_defines.svh"
`default_nettype none
module tcgev_gpio
	import tcgev_pkg::*;
#(
	parameter int unsigned DEB_CYC = `TCGEV_DEB_CYC
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [`TCGEV_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`TCGEV_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Contact inputs, low when closed
	input wire logic [5:0] par_in_n,
	input wire logic vitc_enable_n,
	input wire logic bypass_n,
	// Time base from the code logic
	input wire logic frame_tick,
	input wire tcgev_tc_t reader_time,
	input wire tcgev_tc_t gen_time,
	input wire logic ref_valid,
	input wire logic char_key_pulse,
	// Open-collector outputs
	input wire logic [1:0] assignable_output_i,
	output logic [1:0] assignable_output_o,
	output logic [1:0] assignable_output_oe,
	// Controls to the generator, reader, inserter and bypass relay
	output logic char_inserter_on,
	output logic vitc_gen_on,
	output logic bypass_relay_on,
	output logic resync_load,
	output logic reader_ltc_sel,
	output logic reader_vitc_sel,
	output logic gen_hold,
	output logic gen_set,
	output logic gen_set_reload,
	output logic [7:0] generated_user_bits,
	output logic ub_from_serial
);
	localparam int unsigned NP = `TCGEV_NPIN;
	localparam int unsigned CW = $clog2(DEB_CYC + 1);

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic map_ok(input logic [`TCGEV_ADDR_W-1:0] a);
		map_ok = (a[1:0] == 2'h0) && (a <= `TCGEV_OFF_STAT);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		end
		merge = r;
	endfunction

	// ****************************************
	// Contact synchroniser and debounce
	// ****************************************
	logic [NP-1:0] raw;
	logic [NP-1:0] s1_r;
	logic [NP-1:0] s2_r;
	logic [NP-1:0] s3_r;
	logic [NP-1:0] db_r;
	logic [NP-1:0] dbp_r;
	logic [NP-1:0] fall;
	logic [NP-1:0] rise;
	logic [CW-1:0] deb_r [NP];

	assign raw = {bypass_n, vitc_enable_n, par_in_n};

	genvar g;
	generate
		for (g = 0; g < NP; g++)
		begin : g_deb
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					s1_r[g] <= 1'b1;
					s2_r[g] <= 1'b1;
					s3_r[g] <= 1'b1;
				end
				else
				begin
					s1_r[g] <= raw[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
				end
			end

			// A level is taken only after it has held for the whole window.
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					deb_r[g] <= '0;
					db_r[g] <= 1'b1;
				end
				else if (s2_r[g] != s3_r[g] || s3_r[g] == db_r[g])
					deb_r[g] <= '0;
				else if (deb_r[g] == CW'(DEB_CYC - 1))
				begin
					deb_r[g] <= '0;
					db_r[g] <= s3_r[g];
				end
				else
					deb_r[g] <= deb_r[g] + 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dbp_r <= '1;
		else
			dbp_r <= db_r;
	end

	assign fall = dbp_r & ~db_r;
	assign rise = ~dbp_r & db_r;

	// ****************************************
	// Register state
	// ****************************************
	logic [`TCGEV_CTRL_W-1:0] ctrl_r;
	logic [7:0] dur_r;
	tcgev_tc_t reader_match_time_r;
	tcgev_tc_t generator_match_time_r;
	logic [7:0] ub_ser_r;
	logic ub_src_r;
	logic rctl;
	logic conv;

	assign rctl = ctrl_r[`TCGEV_CTRL_RCTL];
	assign conv = ctrl_r[`TCGEV_CTRL_CONV];

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	logic aw_have_r;
	logic w_have_r;
	logic [`TCGEV_ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic do_wr;
	logic [31:0] ctrl_wd;
	logic [31:0] dur_wd;

	assign ctrl_wd = merge(32'(ctrl_r), w_data_r, w_strb_r);
	assign dur_wd = merge(32'(dur_r), w_data_r, w_strb_r);

	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready = ~w_have_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign do_wr = aw_have_r & w_have_r & ~bvalid_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
		end
		else if (s_axi_awvalid && !aw_have_r)
		begin
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end
		else if (do_wr)
			aw_have_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end
		else if (s_axi_wvalid && !w_have_r)
		begin
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end
		else if (do_wr)
			w_have_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= `TCGEV_RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= map_ok(aw_addr_r) ? `TCGEV_RESP_OKAY
				: `TCGEV_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	function automatic logic wr_at(input logic [`TCGEV_ADDR_W-1:0] off);
		wr_at = do_wr && aw_addr_r == off;
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= `TCGEV_CTRL_RST;
			dur_r <= `TCGEV_DUR_RST;
		end
		else
		begin
			if (wr_at(`TCGEV_OFF_CTRL))
				ctrl_r <= ctrl_wd[`TCGEV_CTRL_W-1:0];
			if (wr_at(`TCGEV_OFF_DUR))
				dur_r <= dur_wd[7:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reader_match_time_r <= '0;
			generator_match_time_r <= '0;
		end
		else
		begin
			if (wr_at(`TCGEV_OFF_READER_MATCH_TIME))
				reader_match_time_r <= merge(reader_match_time_r, w_data_r, w_strb_r);
			if (wr_at(`TCGEV_OFF_GENERATOR_MATCH_TIME))
				generator_match_time_r <= merge(generator_match_time_r, w_data_r, w_strb_r);
		end
	end

	// ****************************************
	// Event registers
	// ****************************************
	logic [3:0] arm_cmd;
	tcgev_evt_t evt_r [2];
	logic [1:0] match;
	logic [1:0] fire;

	assign arm_cmd = (do_wr && aw_addr_r == `TCGEV_OFF_ARM
		&& w_strb_r[0]) ? w_data_r[3:0] : 4'h0;
	assign match[0] = frame_tick && reader_time == reader_match_time_r;
	assign match[1] = frame_tick && gen_time == generator_match_time_r;

	generate
		for (g = 0; g < 2; g++)
		begin : g_evt
			logic c_one;
			logic c_cont;
			assign c_one = arm_cmd[2*g];
			assign c_cont = arm_cmd[2*g+1];
			assign fire[g] = match[g] && evt_r[g] != EVT_OFF;

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					evt_r[g] <= EVT_OFF;
				else if (c_one)
					evt_r[g] <= (evt_r[g] == EVT_ONE)
						? EVT_OFF : EVT_ONE;
				else if (c_cont)
					evt_r[g] <= (evt_r[g] == EVT_CONT)
						? EVT_OFF : EVT_CONT;
				else
				begin
					case (evt_r[g])
						EVT_ONE:
						begin
							if (match[g])
								evt_r[g] <= EVT_OFF;
						end
						EVT_CONT:
							evt_r[g] <= EVT_CONT;
						EVT_OFF:
							evt_r[g] <= EVT_OFF;
						default:
							evt_r[g] <= EVT_OFF;
					endcase
				end
			end
		end
	endgenerate

	// ****************************************
	// Assignable outputs
	// ****************************************
	logic sec_tick;
	logic min_tick;
	logic [1:0] oe_r;

	assign sec_tick = frame_tick && gen_time.ff == 8'h00;
	assign min_tick = sec_tick && gen_time.ss == 8'h00;
	assign assignable_output_o = 2'h0;
	assign assignable_output_oe = oe_r;

	generate
		for (g = 0; g < 2; g++)
		begin : g_out
			tcgev_gpo_fn_t fn;
			logic trig;
			logic [7:0] cnt_r;
			assign fn = tcgev_gpo_fn_t'(ctrl_r[`TCGEV_CTRL_OUT1+3*g +: 3]);

			always_comb
			begin
				case (fn)
					GPO_RDR: trig = fire[0];
					GPO_GEN: trig = fire[1];
					GPO_SEC: trig = sec_tick;
					GPO_MIN: trig = min_tick;
					default: trig = 1'b0;
				endcase
			end

			// The count runs in frames and starts on the triggering frame.
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					cnt_r <= '0;
				else if (trig)
					cnt_r <= dur_r;
				else if (frame_tick && cnt_r != 8'h00)
					cnt_r <= cnt_r - 8'h01;
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn || rctl)
					oe_r[g] <= 1'b0;
				else if (fn == GPO_REF)
					oe_r[g] <= ~ref_valid;
				else
					oe_r[g] <= cnt_r != 8'h00;
			end
		end
	endgenerate

	// ****************************************
	// Dedicated inputs
	// ****************************************
	logic char_r;
	logic vitc_r;
	logic byp_r;
	logic resync_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			char_r <= 1'b0;
		else if ((fall[`TCGEV_PIN_CHAR] && !rctl) ^ char_key_pulse)
			char_r <= ~char_r;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vitc_r <= 1'b0;
			byp_r <= 1'b0;
		end
		else
		begin
			if (fall[`TCGEV_PIN_VITC])
				vitc_r <= 1'b1;
			else if (rise[`TCGEV_PIN_VITC])
				vitc_r <= 1'b0;
			byp_r <= ~db_r[`TCGEV_PIN_BYP];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			resync_r <= 1'b0;
		else
			resync_r <= rise[`TCGEV_PIN_RESYNC] && !rctl
				&& !conv;
	end

	// ****************************************
	// Assignable inputs
	// ****************************************
	logic [3:0] fn_r;
	logic reload_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || rctl)
			fn_r <= 4'h0;
		else
		begin
			for (int k = 0; k < 2; k++)
			begin
				if (fall[`TCGEV_PIN_IN1+k])
					fn_r[ctrl_r[`TCGEV_CTRL_IN1+2*k +: 2]] <= 1'b1;
				else if (rise[`TCGEV_PIN_IN1+k])
					fn_r[ctrl_r[`TCGEV_CTRL_IN1+2*k +: 2]] <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reload_r <= 1'b0;
		else
			reload_r <= frame_tick && fn_r[GPI_SET]
				&& !rctl;
	end

	// ****************************************
	// Remote user bits
	// ****************************************
	logic [5:0] act;
	logic [7:0] pat;
	logic [7:0] ub_r;

	assign act = ~db_r[5:0];
	assign pat = (act == 6'h00) ? 8'h00
		: (`TCGEV_UB_MARK | {2'h0, act});

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ub_src_r <= 1'b0;
			ub_ser_r <= '0;
		end
		else if (wr_at(`TCGEV_OFF_UB) && w_strb_r[0])
		begin
			ub_src_r <= 1'b1;
			ub_ser_r <= w_data_r[7:0];
		end
		else if ((fall[5:0] | rise[5:0]) != 6'h00)
			ub_src_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rctl)
			ub_r <= 8'h00;
		else
			ub_r <= ub_src_r ? ub_ser_r : pat;
	end

	assign char_inserter_on = char_r;
	assign vitc_gen_on = vitc_r;
	assign bypass_relay_on = byp_r;
	assign resync_load = resync_r;
	assign reader_ltc_sel = fn_r[GPI_LTC];
	assign reader_vitc_sel = fn_r[GPI_VITC];
	assign gen_hold = fn_r[GPI_HOLD];
	assign gen_set = fn_r[GPI_SET];
	assign gen_set_reload = reload_r;
	assign generated_user_bits = ub_r;
	assign ub_from_serial = ub_src_r;

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [31:0] rmux;

	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_comb
	begin
		case (s_axi_araddr)
			`TCGEV_OFF_CTRL: rmux = 32'(ctrl_r);
			`TCGEV_OFF_DUR: rmux = 32'(dur_r);
			`TCGEV_OFF_READER_MATCH_TIME: rmux = reader_match_time_r;
			`TCGEV_OFF_GENERATOR_MATCH_TIME: rmux = generator_match_time_r;
			`TCGEV_OFF_ARM: rmux = 32'({evt_r[1], evt_r[0]});
			`TCGEV_OFF_UB: rmux = 32'({ub_src_r, ub_r});
			`TCGEV_OFF_STAT: rmux = 32'({assignable_output_i,
				oe_r, fn_r, resync_r, byp_r, vitc_r, char_r, db_r});
			default: rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `TCGEV_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rmux;
			rresp_r <= map_ok(s_axi_araddr) ? `TCGEV_RESP_OKAY
				: `TCGEV_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end
endmodule // tcgev_gpio
`default_nettype wire

// file: verif/tcgev_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module tcgev_contacts #(
	parameter int DEB = 4
)(
	// Clock
	input wire logic aclk,
	// Contacts, low when closed
	output logic [5:0] par_in_n,
	output logic vitc_enable_n,
	output logic bypass_n,
	// Open-collector loads with pull-ups
	input wire logic [1:0] assignable_output_oe,
	output logic [1:0] assignable_output_i
);
	logic [7:0] closed_r = 8'h00;
	assign {bypass_n, vitc_enable_n, par_in_n} = ~closed_r;
	// A released output floats up to the pull-up level.
	assign assignable_output_i = ~assignable_output_oe;
	// Every change bounces before it settles, then waits out the filter.
	task automatic set(input int i, input logic c);
		repeat (2)
		begin
			@(posedge aclk) closed_r[i] <= c;
			@(posedge aclk) closed_r[i] <= !c;
		end
		@(posedge aclk) closed_r[i] <= c;
		repeat (DEB + 12) @(posedge aclk);
	endtask
endmodule // tcgev_contacts
`default_nettype wire

// file: verif/tcgev_gpio_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tcgev_gpio_properties #(
	parameter int unsigned DEB_CYC = 4
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Contacts and time base
	input wire logic vitc_enable_n,
	input wire logic bypass_n,
	input wire logic frame_tick,
	input wire logic ref_valid,
	// Outputs watched
	input wire logic [1:0] assignable_output_o,
	input wire logic [1:0] assignable_output_oe,
	input wire logic vitc_gen_on,
	input wire logic bypass_relay_on,
	input wire logic gen_set_reload
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ********************
	// Bus
	// ********************
	sequence wr_taken;
		!s_axi_awready && !s_axi_wready;
	endsequence
	sequence wr_answer;
		wr_taken ##1 s_axi_bvalid;
	endsequence
	write_order_a: assert property ($fell(s_axi_awready) &&
		$fell(s_axi_wready) |-> wr_answer) else $error("late write answer");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready wrong");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("late read answer");
	// ********************
	// Contacts and outputs
	// ********************
	vitc_follow_a: assert property ($changed(vitc_gen_on) |->
		vitc_gen_on == !$past(vitc_enable_n, DEB_CYC + 2))
		else $error("vitc generator moved alone");
	bypass_follow_a: assert property ($changed(bypass_relay_on) |->
		bypass_relay_on == !$past(bypass_n, DEB_CYC + 2))
		else $error("bypass relay moved alone");
	reload_tick_a: assert property (gen_set_reload |->
		$past(frame_tick)) else $error("reload off frame");
	oe_idle_a: assert property (assignable_output_o == 2'h0)
		else $error("output data not low");
	oe_cause_a: assert property ((assignable_output_oe &
		~$past(assignable_output_oe)) != 2'h0 |->
		$past(frame_tick, 2) || !$past(ref_valid))
		else $error("output fired without cause");
endmodule // tcgev_gpio_properties
bind tcgev_gpio tcgev_gpio_properties #(.DEB_CYC(DEB_CYC)) props (
	.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .vitc_enable_n, .bypass_n,
	.frame_tick, .ref_valid, .assignable_output_o, .assignable_output_oe,
	.vitc_gen_on, .bypass_relay_on, .gen_set_reload
);
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import tcgev_pkg::*;
;
	typedef struct packed {int pin; logic [7:0] ub;} tcgev_row_t;
	tcgev_row_t rows [6] = '{'{0, 8'h81}, '{1, 8'h82}, '{2, 8'h84},
		'{3, 8'h88}, '{4, 8'h90}, '{5, 8'ha0}};
	logic aclk = 1'b0, aresetn = 1'b0, frame_tick = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rd_q, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic ref_valid = 1'b1, char_key_pulse = 1'b0;
	tcgev_tc_t reader_time = 32'h0, gen_time = 32'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, vitc_enable_n, bypass_n, char_inserter_on;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp_q, oe_q;
	logic [1:0] assignable_output_i, assignable_output_o, assignable_output_oe;
	logic [5:0] par_in_n;
	logic vitc_gen_on, bypass_relay_on, resync_load, reader_ltc_sel;
	logic reader_vitc_sel, gen_hold, gen_set, gen_set_reload, ub_from_serial;
	logic [7:0] generated_user_bits;
	logic [2:0] ft = 3'h0;
	int bad_count = 0, check_count = 0, rs_n = 0, rl_n = 0;
	int rise [2];
	int ticks [2];
	tcgev_gpio #(.DEB_CYC(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .par_in_n,
		.vitc_enable_n, .bypass_n, .frame_tick, .reader_time, .gen_time,
		.ref_valid, .char_key_pulse, .assignable_output_i,
		.assignable_output_o, .assignable_output_oe, .char_inserter_on,
		.vitc_gen_on, .bypass_relay_on, .resync_load, .reader_ltc_sel,
		.reader_vitc_sel, .gen_hold, .gen_set, .gen_set_reload,
		.generated_user_bits, .ub_from_serial);
	tcgev_contacts #(.DEB(4)) m (.aclk, .par_in_n, .vitc_enable_n,
		.bypass_n, .assignable_output_oe, .assignable_output_i);
	// ********************
	// Clock, frames and pulse counters
	// ********************
	initial
	begin
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		ft <= ft + 3'h1;
		frame_tick <= ft == 3'h7;
		oe_q <= assignable_output_oe;
		rs_n <= rs_n + int'(resync_load);
		rl_n <= rl_n + int'(gen_set_reload);
		for (int k = 0; k < 2; k++)
		begin
			rise[k] <= rise[k] + int'(assignable_output_oe[k] && !oe_q[k]);
			ticks[k] <= ticks[k] + int'(assignable_output_oe[k] && frame_tick);
		end
	end
	// ********************
	// Tasks
	// ********************
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic fail;
		bad_count++;
		give_verdict();
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic axi(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (w ? s_axi_bvalid : s_axi_rvalid)
				break;
		end
		resp_q = w ? s_axi_bresp : s_axi_rresp;
		rd_q = s_axi_rdata;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (i == 40)
			fail();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi(1'b1, a, d);
		chk(32'(resp_q), 32'h0);
		repeat (3) @(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		axi(1'b0, a, 32'h0);
		chk(rd_q, e);
	endtask
	task automatic press(input int i);
		m.set(i, 1'b1);
		m.set(i, 1'b0);
	endtask
	task automatic clr;
		#1;
		rl_n = 0;
		rise = '{0, 0};
		ticks = '{0, 0};
	endtask
	task automatic fwait;
		int i;
		for (i = 0; i < 9; i++)
		begin
			@(posedge aclk);
			if (frame_tick)
				break;
		end
		if (i == 9)
			fail();
	endtask
	task automatic frame(input tcgev_tc_t r, input tcgev_tc_t g);
		fwait();
		reader_time <= r;
		gen_time <= g;
		fwait();
		reader_time <= 32'h0;
		gen_time <= 32'h1;
		repeat (40) @(posedge aclk);
	endtask
	// ********************
	// Sequence
	// ********************
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({char_inserter_on, vitc_gen_on, bypass_relay_on, gen_set,
			gen_hold, ub_from_serial, generated_user_bits}), 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h1);
		rd(8'h10, 32'h9);
		axi(1'b0, 8'h1c, 32'h0);
		chk({rd_q[29:0], resp_q}, 32'h2);
		axi(1'b1, 8'h20, 32'h1);
		chk(32'(resp_q), 32'h2);
		wr(8'h00, 32'h1);
		for (int n = 0; n < 6; n++)
		begin
			m.set(rows[n].pin, 1'b1);
			chk(32'(generated_user_bits), 32'(rows[n].ub));
			m.set(rows[n].pin, 1'b0);
			chk(32'(generated_user_bits), 32'h0);
		end
		chk(32'(char_inserter_on) | rs_n, 32'h0);
		m.set(0, 1'b1);
		wr(8'h14, 32'h5a);
		m.set(6, 1'b1);
		m.set(7, 1'b1);
		chk(32'({vitc_gen_on, bypass_relay_on, ub_from_serial,
			generated_user_bits}), 32'h75a);
		m.set(0, 1'b0);
		chk(32'({ub_from_serial, generated_user_bits}), 32'h0);
		m.set(6, 1'b0);
		m.set(7, 1'b0);
		chk(32'({vitc_gen_on, bypass_relay_on}), 32'h0);
		wr(8'h00, 32'h0);
		press(0);
		chk(32'(char_inserter_on), 32'h1);
		char_key_pulse <= 1'b1;
		@(posedge aclk);
		char_key_pulse <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(32'(char_inserter_on), 32'h0);
		press(1);
		chk(rs_n, 32'h1);
		wr(8'h00, 32'h2);
		press(1);
		chk(rs_n, 32'h1);
		for (int f = 0; f < 4; f++)
		begin
			wr(8'h00, 32'(f << 2 | (3 - f) << 4));
			clr();
			m.set(2, 1'b1);
			m.set(3, 1'b1);
			chk(32'({gen_set, gen_hold, reader_vitc_sel, reader_ltc_sel}),
				32'(1 << f | 1 << (3 - f)));
			chk(32'(rl_n != 0), 32'(f == 0 || f == 3));
			m.set(2, 1'b0);
			m.set(3, 1'b0);
			chk(32'({gen_set, gen_hold, reader_vitc_sel, reader_ltc_sel}),
				32'h0);
		end
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h680);
		clr();
		frame(32'h0, 32'h100);
		chk(ticks[0] << 4 | ticks[1], 32'h30);
		clr();
		frame(32'h0, 32'h10000);
		chk(ticks[0] << 4 | ticks[1], 32'h33);
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h200);
		wr(8'h08, 32'h01020304);
		wr(8'h0c, 32'h05060708);
		wr(8'h10, 32'h1);
		rd(8'h10, 32'ha);
		clr();
		repeat (2) frame(32'h01020304, 32'h1);
		chk(rise[0], 32'h1);
		rd(8'h10, 32'h9);
		wr(8'h10, 32'h2);
		rd(8'h10, 32'hc);
		clr();
		repeat (2) frame(32'h01020304, 32'h1);
		chk(rise[0], 32'h2);
		wr(8'h10, 32'h2);
		rd(8'h10, 32'h9);
		wr(8'h10, 32'h4);
		clr();
		frame(32'h0, 32'h05060708);
		chk(rise[1] << 4 | rise[0], 32'h10);
		wr(8'h00, 32'h100);
		ref_valid <= 1'b0;
		repeat (30) @(posedge aclk);
		chk(32'({assignable_output_i, assignable_output_oe}),
			32'h9);
		wr(8'h00, 32'h101);
		chk(32'(assignable_output_oe), 32'h0);
		wr(8'h00, 32'h100);
		ref_valid <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(32'(assignable_output_oe), 32'h0);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
